// [aotb_trim_bank.sv]
// Offset and fine gain trim register bank with AXI4-Lite access
//
// Operation
// - Offset registers 16 bits, correction in 11:0
// - Core 3 offset follows input C or D
// - Gain registers 8 bits, correction in 4:0
// - Core 2 gain follows input A or B
// - Offset trims load fuse defaults, readable and writable except while offsetCalBusy is high (SLVERR)
// - Gain trims load fuse defaults, readable, writable
// - Offset correction is unsigned
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module aotb_trim_bank (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // AXI4-Lite write address and data
  input  wire logic [aotb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [aotb_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [aotb_pkg::STRB_W-1:0] s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read
  input  wire logic [aotb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [aotb_pkg::DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Fuse defaults
  input  wire logic                       fuseLoad,
  input  wire aotb_pkg::aotb_trims_t      fuseTrims,
  // Calibration engine
  input  wire logic                       offsetCalBusy,
  // Converter sampling
  input  wire logic                       sampleStrobe,
  input  wire logic                       core2SelB,
  input  wire logic                       core3SelD,
  // Trims applied to the cores
  output aotb_pkg::aotb_applied_t         appliedTrims
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Byte-lane merge of a write onto the current register value
  function automatic logic [aotb_pkg::DATA_W-1:0] mergeLanes(
    input logic [aotb_pkg::DATA_W-1:0] oldVal,
    input logic [aotb_pkg::DATA_W-1:0] newVal,
    input logic [aotb_pkg::STRB_W-1:0] strb
  );
    logic [aotb_pkg::DATA_W-1:0] res;
    res = oldVal;
    for (int i = 0; i < aotb_pkg::STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Word-aligned address compare, low two bits ignored
  function automatic logic addrHit(
    input logic [aotb_pkg::ADDR_W-1:0] addr,
    input logic [aotb_pkg::ADDR_W-1:0] reg_addr
  );
    return addr[aotb_pkg::ADDR_W-1:2] == reg_addr[aotb_pkg::ADDR_W-1:2];
  endfunction

  function automatic logic isOffsetReg(input logic [aotb_pkg::ADDR_W-1:0] addr);
    return addrHit(addr, aotb_pkg::ADDR_OFS_C3C) || addrHit(addr, aotb_pkg::ADDR_OFS_C3D) ||
           addrHit(addr, aotb_pkg::ADDR_OFS_C4) || addrHit(addr, aotb_pkg::ADDR_OFS_C5);
  endfunction

  function automatic logic isGainReg(input logic [aotb_pkg::ADDR_W-1:0] addr);
    return addrHit(addr, aotb_pkg::ADDR_GAIN_C0) || addrHit(addr, aotb_pkg::ADDR_GAIN_C1) ||
           addrHit(addr, aotb_pkg::ADDR_GAIN_C2A) || addrHit(addr, aotb_pkg::ADDR_GAIN_C2B);
  endfunction

  // Merge onto a zero-extended offset field, keep the field only
  function automatic logic [aotb_pkg::OFS_W-1:0] ofsMerge(
    input logic [aotb_pkg::OFS_W-1:0]  oldVal,
    input aotb_pkg::aotb_wreq_t        req
  );
    logic [aotb_pkg::DATA_W-1:0] tmp;
    tmp = mergeLanes({20'h00000, oldVal}, req.data, req.strb);
    return tmp[aotb_pkg::OFS_W-1:0];
  endfunction

  function automatic logic [aotb_pkg::GAIN_W-1:0] gainMerge(
    input logic [aotb_pkg::GAIN_W-1:0] oldVal,
    input aotb_pkg::aotb_wreq_t        req
  );
    logic [aotb_pkg::DATA_W-1:0] tmp;
    tmp = mergeLanes({27'h0000000, oldVal}, req.data, req.strb);
    return tmp[aotb_pkg::GAIN_W-1:0];
  endfunction

  // ---------------------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------------------
  logic                          wrEn;
  aotb_pkg::aotb_wreq_t          wrReq;
  logic [1:0]                    wrResp;
  logic                          rdEn;
  logic [aotb_pkg::ADDR_W-1:0]   rdAddr;
  logic [aotb_pkg::DATA_W-1:0]   rdData;
  logic [1:0]                    rdResp;

  aotb_axil_slave u_slave (
    .clk     (clk),
    .rst     (rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wrEn    (wrEn),
    .wrReq   (wrReq),
    .wrResp  (wrResp),
    .rdEn    (rdEn),
    .rdAddr  (rdAddr),
    .rdData  (rdData),
    .rdResp  (rdResp)
  );

  // ---------------------------------------------------------------------------
  // Trim storage
  // ---------------------------------------------------------------------------
  aotb_pkg::aotb_trims_t trims;
  aotb_pkg::aotb_trims_t next_trims;
  logic                  wrAccept;
  logic                  fuseLoaded;

  always_comb begin
    if (isOffsetReg(wrReq.addr)) begin
      wrResp = offsetCalBusy ? aotb_pkg::RESP_SLVERR : aotb_pkg::RESP_OKAY;
    end else if (isGainReg(wrReq.addr) || addrHit(wrReq.addr, aotb_pkg::ADDR_STATUS)) begin
      wrResp = aotb_pkg::RESP_OKAY;
    end else begin
      wrResp = aotb_pkg::RESP_DECERR;
    end
  end

  assign wrAccept = wrEn && (wrResp == aotb_pkg::RESP_OKAY);

  // fuse defaults, then software write wins
  always_comb begin
    next_trims = fuseLoad ? fuseTrims : trims;
    if (wrAccept) begin
      // only the correction field is stored
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_OFS_C3C)) begin
        next_trims.c3OfsC = ofsMerge(trims.c3OfsC, wrReq);
      end
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_OFS_C3D)) begin
        next_trims.c3OfsD = ofsMerge(trims.c3OfsD, wrReq);
      end
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_OFS_C4)) begin
        next_trims.c4Ofs = ofsMerge(trims.c4Ofs, wrReq);
      end
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_OFS_C5)) begin
        next_trims.c5Ofs = ofsMerge(trims.c5Ofs, wrReq);
      end
      // only the gain field is stored
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_GAIN_C0)) begin
        next_trims.c0Gain = gainMerge(trims.c0Gain, wrReq);
      end
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_GAIN_C1)) begin
        next_trims.c1Gain = gainMerge(trims.c1Gain, wrReq);
      end
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_GAIN_C2A)) begin
        next_trims.c2GainA = gainMerge(trims.c2GainA, wrReq);
      end
      if (addrHit(wrReq.addr, aotb_pkg::ADDR_GAIN_C2B)) begin
        next_trims.c2GainB = gainMerge(trims.c2GainB, wrReq);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trims <= aotb_pkg::TRIMS_RESET;
    end else begin
      trims <= next_trims;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fuseLoaded <= 1'b0;
    end else if (fuseLoad) begin
      fuseLoaded <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------------------
  // unsigned field, zero above it
  always_comb begin
    rdData = '0;
    rdResp = aotb_pkg::RESP_OKAY;
    if (isOffsetReg(rdAddr) && offsetCalBusy) begin
      rdResp = aotb_pkg::RESP_SLVERR;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_OFS_C3C)) begin
      rdData[aotb_pkg::OFS_W-1:0] = trims.c3OfsC;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_OFS_C3D)) begin
      rdData[aotb_pkg::OFS_W-1:0] = trims.c3OfsD;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_OFS_C4)) begin
      rdData[aotb_pkg::OFS_W-1:0] = trims.c4Ofs;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_OFS_C5)) begin
      rdData[aotb_pkg::OFS_W-1:0] = trims.c5Ofs;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_GAIN_C0)) begin
      rdData[aotb_pkg::GAIN_W-1:0] = trims.c0Gain;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_GAIN_C1)) begin
      rdData[aotb_pkg::GAIN_W-1:0] = trims.c1Gain;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_GAIN_C2A)) begin
      rdData[aotb_pkg::GAIN_W-1:0] = trims.c2GainA;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_GAIN_C2B)) begin
      rdData[aotb_pkg::GAIN_W-1:0] = trims.c2GainB;
    end else if (addrHit(rdAddr, aotb_pkg::ADDR_STATUS)) begin
      rdData[aotb_pkg::ST_CORE2_SEL_B] = core2SelB;
      rdData[aotb_pkg::ST_CORE3_SEL_D] = core3SelD;
      rdData[aotb_pkg::ST_CAL_BUSY]    = offsetCalBusy;
      rdData[aotb_pkg::ST_FUSE_LOADED] = fuseLoaded;
    end else begin
      rdResp = aotb_pkg::RESP_DECERR;
    end
  end

  // ---------------------------------------------------------------------------
  // Trims applied to the cores
  // ---------------------------------------------------------------------------
  // latched at each sample start only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      appliedTrims <= '0;
    end else if (sampleStrobe) begin
      // core 3 offset by selected input
      appliedTrims.ofs3   <= core3SelD ? trims.c3OfsD : trims.c3OfsC;
      appliedTrims.c4Ofs  <= trims.c4Ofs;
      appliedTrims.c5Ofs  <= trims.c5Ofs;
      appliedTrims.c0Gain <= trims.c0Gain;
      appliedTrims.c1Gain <= trims.c1Gain;
      // core 2 gain by selected input
      appliedTrims.gain2  <= core2SelB ? trims.c2GainB : trims.c2GainA;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_ofs_c5_write;
    wrEn && addrHit(wrReq.addr, aotb_pkg::ADDR_OFS_C5) && !offsetCalBusy;
  endsequence

  sequence s_ofs_c5_write_then_sample;
    s_ofs_c5_write ##[1:2] (sampleStrobe && !wrEn) [*1];
  endsequence

  property p_ofs_c4_field;
    wrEn && !fuseLoad && !offsetCalBusy && addrHit(wrReq.addr, aotb_pkg::ADDR_OFS_C4)
      && wrReq.strb == 4'hf
      |=> trims.c4Ofs == $past(wrReq.data[11:0]);
  endproperty
  a_ofs_c4_field: assert property (p_ofs_c4_field)
    else $error("Offset write did not store bits 11:0");

  property p_core3_select;
    sampleStrobe |=> appliedTrims.ofs3 == ($past(core3SelD) ? $past(trims.c3OfsD)
                                                            : $past(trims.c3OfsC));
  endproperty
  a_core3_select: assert property (p_core3_select)
    else $error("Core 3 offset does not follow the selected input");

  property p_gain_c0_field;
    wrEn && !fuseLoad && addrHit(wrReq.addr, aotb_pkg::ADDR_GAIN_C0) && wrReq.strb[0]
      |=> trims.c0Gain == $past(wrReq.data[4:0]);
  endproperty
  a_gain_c0_field: assert property (p_gain_c0_field)
    else $error("Gain write did not store bits 4:0");

  property p_core2_select;
    sampleStrobe |=> appliedTrims.gain2 == ($past(core2SelB) ? $past(trims.c2GainB)
                                                             : $past(trims.c2GainA));
  endproperty
  a_core2_select: assert property (p_core2_select)
    else $error("Core 2 gain does not follow the selected input");

  property p_fuse_offsets;
    fuseLoad && !wrEn |=> trims.c3OfsC == $past(fuseTrims.c3OfsC)
      && trims.c5Ofs == $past(fuseTrims.c5Ofs) && fuseLoaded;
  endproperty
  a_fuse_offsets: assert property (p_fuse_offsets)
    else $error("Offset trims did not take fuse defaults");

  property p_fuse_gains;
    fuseLoad && !wrEn |=> trims.c1Gain == $past(fuseTrims.c1Gain)
      && trims.c2GainB == $past(fuseTrims.c2GainB);
  endproperty
  a_fuse_gains: assert property (p_fuse_gains)
    else $error("Gain trims did not take fuse defaults");

  property p_read_unsigned;
    rdEn && !offsetCalBusy && addrHit(rdAddr, aotb_pkg::ADDR_OFS_C4)
      |=> s_axi_rvalid && s_axi_rdata == {20'h00000, $past(trims.c4Ofs)};
  endproperty
  a_read_unsigned: assert property (p_read_unsigned)
    else $error("Offset read is not the zero-extended field");

  property p_busy_refused;
    wrEn && offsetCalBusy && isOffsetReg(wrReq.addr) && !fuseLoad
      |=> $stable(trims) ##0 s_axi_bresp == aotb_pkg::RESP_SLVERR;
  endproperty
  a_busy_refused: assert property (p_busy_refused)
    else $error("Offset write accepted during calibration");

  property p_hold_between_samples;
    !sampleStrobe |=> $stable(appliedTrims);
  endproperty
  a_hold_between_samples: assert property (p_hold_between_samples)
    else $error("Applied trims changed without a sample");

  property p_new_value_next_sample;
    s_ofs_c5_write_then_sample |=> appliedTrims.c5Ofs == $past(trims.c5Ofs, 1);
  endproperty
  a_new_value_next_sample: assert property (p_new_value_next_sample)
    else $error("Written offset not used on the next sample");

endmodule // aotb_trim_bank

`default_nettype wire

// [aotb_pkg.sv]
// Package: register map, field layout and carrier types of the trim bank
package aotb_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;

  // ---------------------------------------------------------------------------
  // Register indices and byte addresses (byte address = index * 4)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_OFS_C3C   = 12'h338;
  localparam logic [ADDR_W-1:0] IDX_OFS_C3D   = 12'h33a;
  localparam logic [ADDR_W-1:0] IDX_OFS_C4    = 12'h33c;
  localparam logic [ADDR_W-1:0] IDX_OFS_C5    = 12'h33e;
  localparam logic [ADDR_W-1:0] IDX_GAIN_C0   = 12'h360;
  localparam logic [ADDR_W-1:0] IDX_GAIN_C1   = 12'h361;
  localparam logic [ADDR_W-1:0] IDX_GAIN_C2A  = 12'h362;
  localparam logic [ADDR_W-1:0] IDX_GAIN_C2B  = 12'h363;
  localparam logic [ADDR_W-1:0] IDX_STATUS    = 12'h368;

  localparam logic [ADDR_W-1:0] ADDR_OFS_C3C  = IDX_OFS_C3C << 2;
  localparam logic [ADDR_W-1:0] ADDR_OFS_C3D  = IDX_OFS_C3D << 2;
  localparam logic [ADDR_W-1:0] ADDR_OFS_C4   = IDX_OFS_C4 << 2;
  localparam logic [ADDR_W-1:0] ADDR_OFS_C5   = IDX_OFS_C5 << 2;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_C0  = IDX_GAIN_C0 << 2;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_C1  = IDX_GAIN_C1 << 2;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_C2A = IDX_GAIN_C2A << 2;
  localparam logic [ADDR_W-1:0] ADDR_GAIN_C2B = IDX_GAIN_C2B << 2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS   = IDX_STATUS << 2;

  // ---------------------------------------------------------------------------
  // Fields, status bits, reset values, responses
  // ---------------------------------------------------------------------------
  localparam int OFS_W  = 12;
  localparam int GAIN_W = 5;

  localparam int ST_CORE2_SEL_B = 0;
  localparam int ST_CORE3_SEL_D = 1;
  localparam int ST_CAL_BUSY    = 2;
  localparam int ST_FUSE_LOADED = 3;

  localparam logic [OFS_W-1:0]  OFS_RESET  = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_RESET = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [OFS_W-1:0]  c3OfsC;
    logic [OFS_W-1:0]  c3OfsD;
    logic [OFS_W-1:0]  c4Ofs;
    logic [OFS_W-1:0]  c5Ofs;
    logic [GAIN_W-1:0] c0Gain;
    logic [GAIN_W-1:0] c1Gain;
    logic [GAIN_W-1:0] c2GainA;
    logic [GAIN_W-1:0] c2GainB;
  } aotb_trims_t;

  typedef struct packed {
    logic [OFS_W-1:0]  ofs3;
    logic [OFS_W-1:0]  c4Ofs;
    logic [OFS_W-1:0]  c5Ofs;
    logic [GAIN_W-1:0] c0Gain;
    logic [GAIN_W-1:0] c1Gain;
    logic [GAIN_W-1:0] gain2;
  } aotb_applied_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } aotb_wreq_t;

  localparam aotb_trims_t TRIMS_RESET = '{OFS_RESET, OFS_RESET, OFS_RESET, OFS_RESET,
                                         GAIN_RESET, GAIN_RESET, GAIN_RESET, GAIN_RESET};

endpackage : aotb_pkg

// [aotb_axil_slave.sv]
// AXI4-Lite slave front end: channel handshakes, request and response holding
`timescale 1ns/1ps
`default_nettype none

module aotb_axil_slave (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Write address and data
  input  wire logic [aotb_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [aotb_pkg::DATA_W-1:0] wdata,
  input  wire logic [aotb_pkg::STRB_W-1:0] wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // Write response
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // Read address and data
  input  wire logic [aotb_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [aotb_pkg::DATA_W-1:0]     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Register file side
  output logic                            wrEn,
  output aotb_pkg::aotb_wreq_t            wrReq,
  input  wire logic [1:0]                 wrResp,
  output logic                            rdEn,
  output logic [aotb_pkg::ADDR_W-1:0]     rdAddr,
  input  wire logic [aotb_pkg::DATA_W-1:0] rdData,
  input  wire logic [1:0]                 rdResp
);

  logic                        awHeld;
  logic                        wHeld;
  logic                        arHeld;
  logic [aotb_pkg::ADDR_W-1:0] awAddrQ;
  logic [aotb_pkg::DATA_W-1:0] wDataQ;
  logic [aotb_pkg::STRB_W-1:0] wStrbQ;

  // One driver for the request carrier, fields held per channel
  assign wrReq  = '{addr: awAddrQ, data: wDataQ, strb: wStrbQ};
  assign wrEn   = awHeld && wHeld;
  assign rdEn   = arHeld;

  // ---------------------------------------------------------------------------
  // Write channels
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready    <= 1'b1;
      awHeld     <= 1'b0;
      awAddrQ    <= '0;
    end else if (awvalid && awready) begin
      awready    <= 1'b0;
      awHeld     <= 1'b1;
      awAddrQ    <= awaddr;
    end else if (wrEn) begin
      awHeld     <= 1'b0;
    end else if (bvalid && bready) begin
      awready    <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wready     <= 1'b1;
      wHeld      <= 1'b0;
      wDataQ     <= '0;
      wStrbQ     <= '0;
    end else if (wvalid && wready) begin
      wready     <= 1'b0;
      wHeld      <= 1'b1;
      wDataQ     <= wdata;
      wStrbQ     <= wstrb;
    end else if (wrEn) begin
      wHeld      <= 1'b0;
    end else if (bvalid && bready) begin
      wready     <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp  <= aotb_pkg::RESP_OKAY;
    end else if (wrEn) begin
      bvalid <= 1'b1;
      bresp  <= wrResp;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Read channels
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      arHeld  <= 1'b0;
      rdAddr  <= '0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= aotb_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      arHeld  <= 1'b1;
      rdAddr  <= araddr;
    end else if (arHeld) begin
      arHeld  <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rdData;
      rresp   <= rdResp;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // aotb_axil_slave

`default_nettype wire

// [tb_top.sv]
// Self-checking testbench for the trim register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        fuseLoad = 0, offsetCalBusy = 0, sampleStrobe = 0;
  logic        core2SelB = 0, core3SelD = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  aotb_pkg::aotb_trims_t   fuseTrims = '{12'h111, 12'h222, 12'h333, 12'h444,
                                         5'h01, 5'h02, 5'h03, 5'h04};
  aotb_pkg::aotb_applied_t appliedTrims;
  int fail_count = 0;
  int checked    = 0;
  logic [11:0] adr [8] = '{aotb_pkg::ADDR_OFS_C3C, aotb_pkg::ADDR_OFS_C3D,
    aotb_pkg::ADDR_OFS_C4, aotb_pkg::ADDR_OFS_C5, aotb_pkg::ADDR_GAIN_C0,
    aotb_pkg::ADDR_GAIN_C1, aotb_pkg::ADDR_GAIN_C2A, aotb_pkg::ADDR_GAIN_C2B};

  always #10 clk = ~clk;

  aotb_trim_bank DUT (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .fuseLoad(fuseLoad),
    .fuseTrims(fuseTrims), .offsetCalBusy(offsetCalBusy), .sampleStrobe(sampleStrobe),
    .core2SelB(core2SelB), .core3SelD(core3SelD), .appliedTrims(appliedTrims));

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(inout int n);
    n++;
    if (n > 200) begin
      chk("handshake", 0, 1);
      summarize();
    end
  endtask

  function automatic logic [31:0] msk(input int i);
    return (i < 4) ? 32'hfff : 32'h1f;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      tick(n);
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      tick(n);
    end while (!s_axi_rvalid);
    v  = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic strobe(input logic b2, input logic b3, input logic [50:0] exp);
    core2SelB    <= b2;
    core3SelD    <= b3;
    sampleStrobe <= 1'b1;
    @(posedge clk);
    sampleStrobe <= 1'b0;
    @(posedge clk);
    chk("applied trims", appliedTrims, exp);
  endtask

  task automatic t_reset_fuse;
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], d, r);
      chk("reset value", d, 0);
    end
    fuseLoad <= 1'b1;
    @(posedge clk);
    fuseLoad <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(adr[i], d, r);
      chk("fuse default", d, (i < 4) ? 32'h111 * (i + 1) : i - 3);
    end
    $display("test reset and fuse done");
  endtask

  task automatic t_rw_applied;
    for (int i = 0; i < 8; i++) begin
      wr(adr[i], msk(i) - i, r);
      chk("write resp", r, aotb_pkg::RESP_OKAY);
      rd(adr[i], d, r);
      chk("readback", d, msk(i) - i);
    end
    chk("applied before strobe", appliedTrims, 0);
    strobe(1'b0, 1'b1, {12'hffe, 12'hffd, 12'hffc, 5'h1b, 5'h1a, 5'h19});
    strobe(1'b1, 1'b0, {12'hfff, 12'hffd, 12'hffc, 5'h1b, 5'h1a, 5'h18});
    $display("test write and apply done");
  endtask

  task automatic t_cal_unmapped;
    offsetCalBusy <= 1'b1;
    wr(aotb_pkg::ADDR_OFS_C4, 32'h5, r);
    chk("busy write resp", r, aotb_pkg::RESP_SLVERR);
    rd(aotb_pkg::ADDR_OFS_C4, d, r);
    chk("busy read resp", r, aotb_pkg::RESP_SLVERR);
    chk("busy read data", d, 0);
    wr(aotb_pkg::ADDR_GAIN_C0, 32'h3, r);
    chk("busy gain write", r, aotb_pkg::RESP_OKAY);
    rd(aotb_pkg::ADDR_STATUS, d, r);
    chk("status", d, 32'hd);
    offsetCalBusy <= 1'b0;
    rd(aotb_pkg::ADDR_OFS_C4, d, r);
    chk("offset kept", d, 32'hffd);
    rd(aotb_pkg::ADDR_GAIN_C0, d, r);
    chk("gain stored", d, 32'h3);
    wr(aotb_pkg::ADDR_OFS_C5, 32'h123, r);
    chk("write resp", r, aotb_pkg::RESP_OKAY);
    strobe(1'b0, 1'b1, {12'hffe, 12'hffd, 12'h123, 5'h03, 5'h1a, 5'h19});
    wr(12'h004, 32'h1, r);
    chk("unmapped write", r, aotb_pkg::RESP_DECERR);
    rd(12'h004, d, r);
    chk("unmapped read", r, aotb_pkg::RESP_DECERR);
    $display("test calibration and unmapped done");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset_fuse();
    t_rw_applied();
    t_cal_unmapped();
    summarize();
  end
endmodule // tb_top

`default_nettype wire
